// ### pkg/batt_pkg.sv
// Shared constants and types for the pack control and status registers
package batt_pkg;
    // ===============================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_MS = 1000000;
    localparam int SAMPLE_PERIOD_MS = 125;
    localparam int SAMPLE_ON_MS = 2;
    localparam int SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int SAMPLE_ON_CYC = SAMPLE_ON_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int SAMPLE_CNT_W = 24;
    // ===============================
    // Widths and reset values
    localparam int BYTE_W = 8;
    localparam int CTRL_W = 16;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [4:0] STATUS_PAD = 5'h00;
    // ===============================
    // Sense gain factors
    localparam logic [7:0] GAIN_X10 = 8'h0a;
    localparam logic [7:0] GAIN_X25 = 8'h19;
    localparam logic [7:0] GAIN_X80 = 8'h50;
    localparam logic [7:0] GAIN_X160 = 8'ha0;
    // ===============================
    // Register layouts
    typedef struct packed {
        logic balance_ctl_4;
        logic balance_ctl_3;
        logic balance_ctl_2;
        logic balance_ctl_1;
        logic discharge_fet_ctl;
        logic charge_fet_ctl;
        logic sense_gain_hi;
        logic sense_gain_lo;
        logic sleep_request;
        logic [1:0] reserved;
        logic [4:0] unused;
    } ctrl_word_type;
    typedef struct packed {
        logic [4:0] pad;
        logic charge_stat;
        logic discharge_stat;
        logic regulator_stat;
    } status_byte_type;
    typedef enum logic [1:0] {LD_IDLE, LD_HIGH, LD_LOW} load_state_type;
endpackage

// ### verification/host_spi_model.sv
// Host microcontroller model driving the serial instruction stream
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Bench requests
    input wire logic go_write,
    input wire logic abort,
    input wire logic go_read,
    input wire logic [15:0] wdata,
    // Instruction stream
    output logic write_control_instr,
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic frame_end,
    output logic read_status_instr,
    output logic busy
);
    // ===============================
    // Frame sequencer
    logic [1:0] step_reg;
    logic [15:0] word_reg;
    logic abort_reg;
    assign busy = (step_reg != 2'd0);
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            step_reg <= 2'd0;
            word_reg <= 16'h0000;
            abort_reg <= 1'b0;
            write_control_instr <= 1'b0;
            byte_valid <= 1'b0;
            byte_data <= 8'h00;
            frame_end <= 1'b0;
            read_status_instr <= 1'b0;
        end else begin
            write_control_instr <= 1'b0;
            byte_valid <= 1'b0;
            frame_end <= 1'b0;
            read_status_instr <= go_read;
            case (step_reg)
                2'd0: begin
                    // reserved bits always sent as zero
                    if (go_write) begin
                        step_reg <= 2'd1;
                        word_reg <= wdata & 16'hff9f;
                        abort_reg <= abort;
                        write_control_instr <= 1'b1;
                    end else begin
                        // Idle data line never holds a stale byte
                        byte_data <= ~byte_data;
                    end
                end
                2'd1: begin
                    step_reg <= 2'd2;
                    byte_valid <= 1'b1;
                    byte_data <= word_reg[15:8];
                end
                default: begin
                    // Abort drops select before the low byte
                    step_reg <= 2'd0;
                    frame_end <= 1'b1;
                    byte_valid <= !abort_reg;
                    byte_data <= abort_reg ? ~byte_data : word_reg[7:0];
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the pack control and status registers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import batt_pkg::*;
    // ===============================
    // Signals
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic go_write = 1'b0, abort = 1'b0, go_read = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic write_control_instr, byte_valid, frame_end, read_status_instr, busy;
    logic [7:0] byte_data;
    logic supply_below_sleep = 1'b0, wake_event = 1'b0;
    logic overcharge_mode_flag = 1'b0, underdischarge_mode_flag = 1'b0;
    logic overcurrent_mode_flag = 1'b0, regulator_untuned_flag = 1'b0;
    logic low_cell_flag = 1'b0, charge_enable_disable = 1'b0, monitor_mode = 1'b0;
    logic charge_gate_out, discharge_gate_out, sleep_active, ov_uv_detect_en, status_valid;
    logic balance_out_1, balance_out_2, balance_out_3, balance_out_4;
    logic [1:0] sense_gain_code;
    logic [7:0] sense_gain_factor;
    status_byte_type status_byte;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    always #5 mclk = ~mclk;
    // ===============================
    // Instances
    host_spi_model host (.mclk(mclk), .rst_b(rst_b), .go_write(go_write), .abort(abort),
        .go_read(go_read), .wdata(wdata), .write_control_instr(write_control_instr),
        .byte_valid(byte_valid), .byte_data(byte_data), .frame_end(frame_end),
        .read_status_instr(read_status_instr), .busy(busy));
    battery_protect_ctrl_status_regs #(.SAMPLE_PERIOD_CYC(20), .SAMPLE_ON_CYC(3)) uut (
        .mclk(mclk), .rst_b(rst_b), .write_control_instr(write_control_instr),
        .byte_valid(byte_valid), .byte_data(byte_data), .frame_end(frame_end),
        .read_status_instr(read_status_instr), .supply_below_sleep(supply_below_sleep),
        .wake_event(wake_event), .overcharge_mode_flag(overcharge_mode_flag),
        .underdischarge_mode_flag(underdischarge_mode_flag),
        .overcurrent_mode_flag(overcurrent_mode_flag), .regulator_untuned_flag(regulator_untuned_flag),
        .low_cell_flag(low_cell_flag), .charge_enable_disable(charge_enable_disable),
        .monitor_mode(monitor_mode), .charge_gate_out(charge_gate_out),
        .discharge_gate_out(discharge_gate_out), .balance_out_1(balance_out_1),
        .balance_out_2(balance_out_2), .balance_out_3(balance_out_3), .balance_out_4(balance_out_4),
        .sense_gain_code(sense_gain_code), .sense_gain_factor(sense_gain_factor),
        .sleep_active(sleep_active), .ov_uv_detect_en(ov_uv_detect_en),
        .status_byte(status_byte), .status_valid(status_valid));
    // ===============================
    // Helpers
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    function automatic logic [15:0] drive_of(input logic [15:0] w);
        logic [7:0] f;
        case (w[9:8])
            2'b00: f = GAIN_X10;
            2'b01: f = GAIN_X25;
            2'b10: f = GAIN_X80;
            default: f = GAIN_X160;
        endcase
        return {~w[10], ~w[11], w[15:12], w[9:8], f};
    endfunction
    function automatic logic [15:0] drive_seen();
        return {charge_gate_out, discharge_gate_out, balance_out_4, balance_out_3,
            balance_out_2, balance_out_1, sense_gain_code, sense_gain_factor};
    endfunction
    // Outputs settle three edges after the low byte
    task automatic do_write(input logic [15:0] w, input logic ab);
        while (busy) @(posedge mclk);
        @(posedge mclk);
        go_write <= 1'b1;
        wdata <= w;
        abort <= ab;
        @(posedge mclk);
        go_write <= 1'b0;
        repeat (8) @(posedge mclk);
        #1;
    endtask
    task automatic do_read(input logic [7:0] exp);
        @(posedge mclk);
        go_read <= 1'b1;
        @(posedge mclk);
        go_read <= 1'b0;
        @(posedge mclk);
        #1;
        check("status", {7'h00, status_valid, status_byte}, {8'h01, exp});
        @(posedge mclk);
        #1;
        check("status_pulse", 16'(status_valid), 16'h0);
    endtask
    // ===============================
    // Scenarios
    task automatic test_reset();
        check("reset_drive", drive_seen(), drive_of(16'h0000));
        check("reset_sleep", 16'(sleep_active), 16'h0);
    endtask
    task automatic test_fields();
        logic [15:0] w;
        for (int i = 0; i < 4; i++) begin
            w = {4'h1 << i, i[1], i[0], i[1:0], 8'h1f};
            do_write(w, 1'b0);
            check("drive", drive_seen(), drive_of(w));
        end
        do_write(16'hf500, 1'b0);
        do_write(16'h0e00, 1'b1);
        check("aborted", drive_seen(), drive_of(16'hf500));
    endtask
    task automatic test_protect();
        do_write(16'h0c00, 1'b0);
        @(posedge mclk);
        overcharge_mode_flag <= 1'b1;
        @(posedge mclk);
        #1;
        check("ov_gates", 16'({charge_gate_out, discharge_gate_out}), 16'h2);
        do_write(16'h0400, 1'b0);
        check("ov_hold", 16'({charge_gate_out, discharge_gate_out}), 16'h2);
        @(posedge mclk);
        overcharge_mode_flag <= 1'b0;
        @(posedge mclk);
        #1;
        check("ov_release", 16'({charge_gate_out, discharge_gate_out}), 16'h1);
        do_write(16'h0c00, 1'b0);
        @(posedge mclk);
        overcurrent_mode_flag <= 1'b1;
        @(posedge mclk);
        #1;
        check("oc_gates", 16'({charge_gate_out, discharge_gate_out}), 16'h1);
        @(posedge mclk);
        overcurrent_mode_flag <= 1'b0;
        underdischarge_mode_flag <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        check("ud_gates", 16'({charge_gate_out, discharge_gate_out}), 16'h1);
        @(posedge mclk);
        underdischarge_mode_flag <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check("ud_release", 16'({charge_gate_out, discharge_gate_out}), 16'h0);
    endtask
    task automatic test_status();
        logic [5:0] v;
        for (int i = 0; i < 64; i++) begin
            v = i[5:0];
            @(posedge mclk);
            {regulator_untuned_flag, overcurrent_mode_flag, underdischarge_mode_flag} <= v[2:0];
            {overcharge_mode_flag, low_cell_flag, charge_enable_disable} <= v[5:3];
            do_read({5'h00, v[5] | (v[4] & !v[3]), v[0], v[2] | v[1]});
        end
        @(posedge mclk);
        {regulator_untuned_flag, overcurrent_mode_flag, underdischarge_mode_flag} <= 3'h0;
        {overcharge_mode_flag, low_cell_flag, charge_enable_disable} <= 3'h0;
        do_read(8'h00);
    endtask
    task automatic test_sleep();
        do_write(16'hf580, 1'b0);
        check("no_sleep", 16'(sleep_active), 16'h0);
        @(posedge mclk);
        supply_below_sleep <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        check("sleep", 16'(sleep_active), 16'h1);
        @(posedge mclk);
        wake_event <= 1'b1;
        @(posedge mclk);
        wake_event <= 1'b0;
        supply_below_sleep <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        check("wake_sleep", 16'(sleep_active), 16'h0);
        check("wake_drive", drive_seen(), drive_of(16'h0000));
    endtask
    task automatic count_detect(input logic mon, input int exp);
        int n;
        n = 0;
        @(posedge mclk);
        monitor_mode <= mon;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            #1;
            if (ov_uv_detect_en === 1'b1) n++;
        end
        check("detect_count", 16'(n), 16'(exp));
    endtask
    // ===============================
    // Run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        test_reset();
        test_fields();
        test_protect();
        test_status();
        test_sleep();
        count_detect(1'b0, 6);
        count_detect(1'b1, 40);
        complete_run();
    end
endmodule
`default_nettype wire

// ### verilog/battery_protect_ctrl_status_regs.sv
// Control word, status byte and FET gate drive of the pack monitor
`timescale 1ns/10ps
`default_nettype none
// Function
// - Volatile control word, written by instruction only
// - Cleared at power-up and sleep exit
// - Bit 7 enters sleep below threshold
// - Bits 9:8 select sense gain
// - Bit 10 one drives charge gate low
// - Bit 11 one drives discharge gate low
// - Protection holds gates, writes still accepted
// - Bits 15:12 drive balance outputs high
// - Status byte read, bits 7:3 zero
// - Status bit 0: untuned or overcurrent
// - Status bit 1: over-discharge mode
// - Charge enable on: low cell or overcharge
// - Charge enable off: overcharge only
// - Regulator part high until tuned
// - Overcurrent continuous, others periodic
// - Protection turns FET off, release restores
// - Monitor mode makes checking continuous
// - Detectors on 2ms per 125ms
// - Config bit 6 zero enables charge function
module battery_protect_ctrl_status_regs #(
    parameter int SAMPLE_PERIOD_CYC = batt_pkg::SAMPLE_PERIOD_CYC,
    parameter int SAMPLE_ON_CYC = batt_pkg::SAMPLE_ON_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Serial instruction stream
    input wire logic write_control_instr,
    input wire logic byte_valid,
    input wire logic [batt_pkg::BYTE_W-1:0] byte_data,
    input wire logic frame_end,
    input wire logic read_status_instr,
    // Sleep
    input wire logic supply_below_sleep,
    input wire logic wake_event,
    // Protection and analog conditions
    input wire logic overcharge_mode_flag,
    input wire logic underdischarge_mode_flag,
    input wire logic overcurrent_mode_flag,
    input wire logic regulator_untuned_flag,
    input wire logic low_cell_flag,
    input wire logic charge_enable_disable,
    input wire logic monitor_mode,
    // FET and balance drive
    output logic charge_gate_out,
    output logic discharge_gate_out,
    output logic balance_out_1,
    output logic balance_out_2,
    output logic balance_out_3,
    output logic balance_out_4,
    // Analog control
    output logic [1:0] sense_gain_code,
    output logic [7:0] sense_gain_factor,
    output logic sleep_active,
    output logic ov_uv_detect_en,
    // Status read
    output batt_pkg::status_byte_type status_byte,
    output logic status_valid
);
    import batt_pkg::*;

    // ===============================
    // Gain decode
    function automatic logic [7:0] gain_of(input logic [1:0] code);
        case (code)
            2'h0: gain_of = GAIN_X10;
            2'h1: gain_of = GAIN_X25;
            2'h2: gain_of = GAIN_X80;
            default: gain_of = GAIN_X160;
        endcase
    endfunction

    ctrl_word_type ctrl_reg;
    logic commit;
    logic [CTRL_W-1:0] new_word;
    logic any_prot;
    logic discharge_prot;
    status_byte_type status_next;

    // ===============================
    // Instruction byte assembly
    ctrl_word_loader loader (
        .mclk(mclk),
        .rst_b(rst_b),
        .write_start(write_control_instr),
        .byte_valid(byte_valid),
        .byte_data(byte_data),
        .frame_end(frame_end),
        .commit(commit),
        .word(new_word)
    );

    // ===============================
    // Detector sample timer, only OV/UV are gated
    // Overcurrent never gated
    detect_sampler #(
        .PERIOD_CYC(SAMPLE_PERIOD_CYC),
        .ON_CYC(SAMPLE_ON_CYC)
    ) sampler (
        .mclk(mclk),
        .rst_b(rst_b),
        .monitor_mode(monitor_mode),
        .detect_en(ov_uv_detect_en)
    );

    // ===============================
    // Control word
    // Written on commit, cleared on wake
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wake_event) begin
            ctrl_reg <= CTRL_RESET;
        end else if (commit) begin
            ctrl_reg <= new_word;
        end
    end

    // ===============================
    // Sleep
    // Enter only below threshold
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sleep_active <= 1'b0;
        end else if (wake_event) begin
            sleep_active <= 1'b0;
        end else if (ctrl_reg.sleep_request && supply_below_sleep) begin
            sleep_active <= 1'b1;
        end
    end

    // ===============================
    // Sense gain
    // Gain code and factor
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sense_gain_code <= 2'h0;
            sense_gain_factor <= GAIN_X10;
        end else begin
            sense_gain_code <= {ctrl_reg.sense_gain_hi, ctrl_reg.sense_gain_lo};
            sense_gain_factor <= gain_of({ctrl_reg.sense_gain_hi, ctrl_reg.sense_gain_lo});
        end
    end

    // ===============================
    // FET gates, high means FET off
    assign any_prot = overcharge_mode_flag || underdischarge_mode_flag || overcurrent_mode_flag;
    assign discharge_prot = underdischarge_mode_flag || overcurrent_mode_flag;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            charge_gate_out <= 1'b1;
        end else if (overcharge_mode_flag) begin
            charge_gate_out <= 1'b1;
        end else if (!any_prot) begin
            charge_gate_out <= !ctrl_reg.charge_fet_ctl;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            discharge_gate_out <= 1'b1;
        end else if (discharge_prot) begin
            discharge_gate_out <= 1'b1;
        end else if (!any_prot) begin
            discharge_gate_out <= !ctrl_reg.discharge_fet_ctl;
        end
    end

    // ===============================
    // Balance outputs
    // One bit per output
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            balance_out_1 <= 1'b0;
            balance_out_2 <= 1'b0;
            balance_out_3 <= 1'b0;
            balance_out_4 <= 1'b0;
        end else begin
            balance_out_1 <= ctrl_reg.balance_ctl_1;
            balance_out_2 <= ctrl_reg.balance_ctl_2;
            balance_out_3 <= ctrl_reg.balance_ctl_3;
            balance_out_4 <= ctrl_reg.balance_ctl_4;
        end
    end

    // ===============================
    // Live status, sampled into status_byte on a read, nothing cleared by a read
    always_comb begin
        status_next = '0;
        status_next.pad = STATUS_PAD;
        status_next.regulator_stat = regulator_untuned_flag || overcurrent_mode_flag;
        status_next.discharge_stat = underdischarge_mode_flag;
        status_next.charge_stat = overcharge_mode_flag || (!charge_enable_disable && low_cell_flag);
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            status_byte <= '0;
            status_valid <= 1'b0;
        end else begin
            status_valid <= read_status_instr;
            if (read_status_instr) begin
                status_byte <= status_next;
            end
        end
    end

    // ===============================
    // Checks
    chk_wake_clears_word: assert property (
        @(posedge mclk) disable iff (!rst_b)
        wake_event |=> (ctrl_reg == CTRL_RESET))
        else $error("control word not cleared on wake");

    chk_word_only_commit: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (!commit && !wake_event) |=> $stable(ctrl_reg))
        else $error("control word changed without commit");

    chk_sleep_entry: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (ctrl_reg.sleep_request && supply_below_sleep && !wake_event) |=> sleep_active)
        else $error("sleep not entered");

    chk_gain_factor: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (commit && !wake_event && new_word[9:8] == 2'h2) |=> ##1 (sense_gain_factor == GAIN_X80))
        else $error("sense gain factor wrong");

    chk_charge_gate_on: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (ctrl_reg.charge_fet_ctl && !any_prot) |=> !charge_gate_out)
        else $error("charge gate not driven on");

    chk_discharge_gate_off: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (!ctrl_reg.discharge_fet_ctl && !any_prot) |=> discharge_gate_out)
        else $error("discharge gate not driven off");

    chk_gate_hold_prot: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (underdischarge_mode_flag && !overcharge_mode_flag) [*2] |-> $stable(charge_gate_out))
        else $error("charge gate moved during protection");

    chk_overcharge_off: assert property (
        @(posedge mclk) disable iff (!rst_b)
        overcharge_mode_flag |=> charge_gate_out)
        else $error("charge FET not switched off");

    chk_balance_follow: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (commit && !wake_event) |=> ##1 (balance_out_4 == $past(new_word[15], 2)
            && balance_out_1 == $past(new_word[12], 2)))
        else $error("balance output mismatch");

    chk_status_pad_zero: assert property (
        @(posedge mclk) disable iff (!rst_b)
        status_valid |-> (status_byte.pad == STATUS_PAD))
        else $error("status upper bits not zero");

    chk_status_bit0: assert property (
        @(posedge mclk) disable iff (!rst_b)
        read_status_instr |=> (status_byte.regulator_stat
            == ($past(regulator_untuned_flag) || $past(overcurrent_mode_flag))))
        else $error("status bit 0 wrong");

    chk_status_bit1: assert property (
        @(posedge mclk) disable iff (!rst_b)
        read_status_instr |=> (status_byte.discharge_stat == $past(underdischarge_mode_flag)))
        else $error("status bit 1 wrong");

    chk_status_bit2: assert property (
        @(posedge mclk) disable iff (!rst_b)
        read_status_instr |=> (status_byte.charge_stat == ($past(overcharge_mode_flag)
            || (!$past(charge_enable_disable) && $past(low_cell_flag)))))
        else $error("status bit 2 wrong");

    chk_monitor_detect: assert property (
        @(posedge mclk) disable iff (!rst_b)
        monitor_mode |=> ov_uv_detect_en)
        else $error("detectors not continuous in monitor mode");
endmodule
`default_nettype wire

// ### verilog/ctrl_word_loader.sv
// Assembles the two data bytes of a control write instruction
`timescale 1ns/10ps
`default_nettype none
module ctrl_word_loader (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Byte stream
    input wire logic write_start,
    input wire logic byte_valid,
    input wire logic [batt_pkg::BYTE_W-1:0] byte_data,
    input wire logic frame_end,
    // Completed word
    output logic commit,
    output logic [batt_pkg::CTRL_W-1:0] word
);
    import batt_pkg::*;
    load_state_type state_reg;
    logic [BYTE_W-1:0] high_reg;
    // ===============================
    // Sequencer; a frame that ends early commits nothing
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_reg <= LD_IDLE;
            high_reg <= '0;
            commit <= 1'b0;
            word <= CTRL_RESET;
        end else begin
            commit <= 1'b0;
            case (state_reg)
                LD_IDLE: begin
                    if (write_start) begin
                        state_reg <= LD_HIGH;
                    end
                end
                LD_HIGH: begin
                    if (byte_valid) begin
                        high_reg <= byte_data;
                        state_reg <= frame_end ? LD_IDLE : LD_LOW;
                    end else if (frame_end) begin
                        state_reg <= LD_IDLE;
                    end
                end
                LD_LOW: begin
                    if (byte_valid) begin
                        word <= {high_reg, byte_data};
                        commit <= 1'b1;
                        state_reg <= LD_IDLE;
                    end else if (frame_end) begin
                        state_reg <= LD_IDLE;
                    end
                end
                default: begin
                    state_reg <= LD_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### verilog/detect_sampler.sv
// Sample rate timer for the over-charge and over-discharge detectors
`timescale 1ns/10ps
`default_nettype none
module detect_sampler #(
    parameter int PERIOD_CYC = batt_pkg::SAMPLE_PERIOD_CYC,
    parameter int ON_CYC = batt_pkg::SAMPLE_ON_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Mode
    input wire logic monitor_mode,
    // Detector enable
    output logic detect_en
);
    import batt_pkg::*;
    logic [SAMPLE_CNT_W-1:0] cnt_reg;
    // ===============================
    // Free running period counter
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cnt_reg <= '0;
        end else if (cnt_reg == SAMPLE_CNT_W'(PERIOD_CYC - 1)) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            detect_en <= 1'b0;
        end else begin
            detect_en <= monitor_mode || (cnt_reg < SAMPLE_CNT_W'(ON_CYC));
        end
    end
endmodule
`default_nettype wire
